// File: src/cmts_pkg.sv
// Constants for the transmit mailbox scheduler: state codes, widths, buffer indices.
// Assumes a single module clock; no register bus, all controls are ports.
package cmts_pkg;
   localparam int          CMTS_NUM_BUF     = 16;
   localparam int          CMTS_IDX_W       = 4;
   localparam int          CMTS_CODE_W      = 4;
   localparam int          CMTS_ID_W        = 29;
   localparam int          CMTS_DATA_W      = 64;
   localparam int          CMTS_DLC_W       = 4;
   localparam logic [3:0]  CMTS_CODE_INACT  = 4'h0;
   localparam logic [3:0]  CMTS_CODE_TXOFF  = 4'h8;
   localparam logic [3:0]  CMTS_CODE_ABORT  = 4'h9;
   localparam logic [3:0]  CMTS_CODE_TXDATA = 4'hc;
   localparam logic [3:0]  CMTS_IDX_LAST    = 4'hf;
   localparam logic [3:0]  CMTS_IDX_ZERO    = 4'h0;
   typedef enum logic [1:0] {CMTS_IDLE, CMTS_SCAN, CMTS_SEND} cmts_state_type;
endpackage : cmts_pkg

// File: src/cmts_scheduler.sv
// Transmit mailbox scheduler: per-buffer state field, arbitration scan,
// completion flags and masked interrupt request.
// Assumes the bus engine reports intermission end, incoming start of frame
// and frame completion as one-cycle pulses in the module clock domain.
//
// Notes on behaviour
// - Writing 0xC arms a buffer for the next arbitration scan.
// - Writing 0x0 deactivates a buffer completely.
// - Any arming schedules a scan and send, even mid-scan with idle bus.
// - A state-field write after intermission re-runs the scan while idle, or while scanning unless non-arming at the last index; not while a winner is offered.
// - Incoming frame start after intermission also triggers a fresh scan.
// - Abort 0b1001 on active buffer sets done flag; code tells abort or sent.
// - Done flags are readable; interrupt only where mask bit is set.
// - With abort disabled, 0b1000 deactivates; pending frame may go unreported.
`timescale 1ns/1ps
module cmts_scheduler
   import cmts_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    arst_n,
   input  wire logic                    abort_enable_bit,
   input  wire logic                    code_wr,
   input  wire logic [CMTS_IDX_W-1:0]   code_idx,
   input  wire logic [CMTS_CODE_W-1:0]  code_val,
   input  wire logic                    id_wr,
   input  wire logic [CMTS_ID_W-1:0]    id_val,
   input  wire logic                    data_wr,
   input  wire logic [CMTS_DATA_W-1:0]  data_val,
   input  wire logic [CMTS_DLC_W-1:0]   dlc_val,
   input  wire logic [CMTS_NUM_BUF-1:0] flag_clr,
   input  wire logic [CMTS_NUM_BUF-1:0] buffer_irq_mask,
   input  wire logic                    intermission_end,
   input  wire logic                    rx_sof,
   input  wire logic                    tx_ack,
   input  wire logic                    tx_done,
   input  wire logic [CMTS_IDX_W-1:0]   rd_idx,
   output logic      [CMTS_CODE_W-1:0]  rd_code,
   output logic      [CMTS_NUM_BUF-1:0] buffer_done_flag,
   output logic                         irq,
   output logic                         tx_req,
   output logic      [CMTS_ID_W-1:0]    tx_id,
   output logic      [CMTS_DATA_W-1:0]  tx_data,
   output logic      [CMTS_DLC_W-1:0]   tx_dlc
);

////////////////////////////////////////////////////////////////////////////////
// Reset release
   logic rst_s1;
   logic rst_n;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// Buffer storage
   logic [CMTS_CODE_W-1:0] code  [CMTS_NUM_BUF];
   logic [CMTS_ID_W-1:0]   ids   [CMTS_NUM_BUF];
   logic [CMTS_DATA_W-1:0] datas [CMTS_NUM_BUF];
   logic [CMTS_DLC_W-1:0]  dlcs  [CMTS_NUM_BUF];
   cmts_state_type         state;
   logic [CMTS_IDX_W-1:0]  scan_idx;
   logic [CMTS_IDX_W-1:0]  win_idx;
   logic                   win_valid;
   logic                   rescan;
   logic                   tx_busy;

   wire [CMTS_NUM_BUF-1:0] armed;
   wire                    code_arm   = code_wr && (code_val == CMTS_CODE_TXDATA);
   wire                    scan_last  = (scan_idx == CMTS_IDX_LAST);
   wire                    cand_hit   = armed[scan_idx]
                                        && (!win_valid || ids[scan_idx] < ids[win_idx]);
   // A state write during a scan forces another pass, unless it is a non-arming write at the last index:
   // this closes the hole where an arming write lands just after its buffer is examined.
   wire                    trig       = intermission_end || rx_sof || code_wr;

   genvar g;
   generate
      for (g = 0; g < CMTS_NUM_BUF; g++) begin : g_buf
         wire hit      = code_wr && (code_idx == CMTS_IDX_W'(g));
         wire sent     = tx_done && tx_busy && (win_idx == CMTS_IDX_W'(g));
         wire aborting = hit && (code_val == CMTS_CODE_ABORT) && abort_enable_bit
                         && (code[g] == CMTS_CODE_TXDATA);
         assign armed[g] = (code[g] == CMTS_CODE_TXDATA);
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               code[g]             <= CMTS_CODE_INACT;
               buffer_done_flag[g] <= 1'b0;
            end else begin
               if (sent)
                  code[g] <= CMTS_CODE_TXOFF;
               else if (aborting && !(tx_busy && win_idx == CMTS_IDX_W'(g)))
                  code[g] <= CMTS_CODE_ABORT;
               else if (aborting)
                  code[g] <= code[g];
               else if (hit && code_val != CMTS_CODE_ABORT)
                  code[g] <= code_val;
               // Set wins over a clear in the same cycle
               if (sent || (aborting && !(tx_busy && win_idx == CMTS_IDX_W'(g))))
                  buffer_done_flag[g] <= 1'b1;
               else if (flag_clr[g])
                  buffer_done_flag[g] <= 1'b0;
            end
         end
         always_ff @(posedge clk) begin
            if (id_wr && code_idx == CMTS_IDX_W'(g))
               ids[g] <= id_val;
            if (data_wr && code_idx == CMTS_IDX_W'(g)) begin
               datas[g] <= data_val;
               dlcs[g]  <= dlc_val;
            end
         end
      end
   endgenerate

   assign irq     = |(buffer_done_flag & buffer_irq_mask);
   assign tx_req  = (state == CMTS_SEND);

////////////////////////////////////////////////////////////////////////////////
// Arbitration scan: lowest identifier among armed buffers wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state     <= CMTS_IDLE;
         scan_idx  <= CMTS_IDX_ZERO;
         win_idx   <= CMTS_IDX_ZERO;
         win_valid <= 1'b0;
         rescan    <= 1'b0;
         tx_busy   <= 1'b0;
         rd_code   <= CMTS_CODE_INACT;
         tx_id     <= '0;
         tx_data   <= '0;
         tx_dlc    <= '0;
      end else begin
         rd_code <= code[rd_idx];
         unique case (state)
            CMTS_IDLE: begin
               if (trig && !tx_busy) begin
                  state     <= CMTS_SCAN;
                  scan_idx  <= CMTS_IDX_ZERO;
                  win_valid <= 1'b0;
                  rescan    <= 1'b0;
               end
               if (tx_done)
                  tx_busy <= 1'b0;
            end
            CMTS_SCAN: begin
               if (code_wr)
                  rescan <= 1'b1;
               if (cand_hit) begin
                  win_idx   <= scan_idx;
                  win_valid <= 1'b1;
               end
               if (scan_last) begin
                  if (rescan || code_arm) begin
                     scan_idx  <= CMTS_IDX_ZERO;
                     win_valid <= 1'b0;
                     rescan    <= 1'b0;
                  end else if (win_valid || cand_hit) begin
                     state   <= CMTS_SEND;
                     tx_id   <= cand_hit ? ids[scan_idx]   : ids[win_idx];
                     tx_data <= cand_hit ? datas[scan_idx] : datas[win_idx];
                     tx_dlc  <= cand_hit ? dlcs[scan_idx]  : dlcs[win_idx];
                  end else
                     state <= CMTS_IDLE;
               end else
                  scan_idx <= scan_idx + 1'b1;
            end
            CMTS_SEND: begin
               // Winner withdrawn before the engine took it: scan again
               if (!armed[win_idx]) begin
                  state     <= CMTS_SCAN;
                  scan_idx  <= CMTS_IDX_ZERO;
                  win_valid <= 1'b0;
               end else if (tx_ack) begin
                  state   <= CMTS_IDLE;
                  tx_busy <= 1'b1;
               end
            end
         endcase
      end
   end

////////////////////////////////////////////////////////////////////////////////
// Checks
   // A pass that ends with no restart pending must offer whatever is armed
   sequence s_pass_clean;
      state == CMTS_SCAN && scan_last && !rescan && !code_wr && (|armed);
   endsequence

   sequence s_arm_mid_scan;
      state == CMTS_SCAN && code_arm;
   endsequence

   a_arm_reaches_send: assert property (@(posedge clk) disable iff (!rst_n)
      s_pass_clean |=> tx_req)
      else $error("armed buffer never offered for transmission");

   a_arm_rescans: assert property (@(posedge clk) disable iff (!rst_n)
      s_arm_mid_scan |=> state == CMTS_SCAN && (rescan || scan_idx == CMTS_IDX_ZERO))
      else $error("arming during a scan did not force another pass");

   a_write_takes_code: assert property (@(posedge clk) disable iff (!rst_n)
      code_wr && code_val != CMTS_CODE_ABORT && !tx_done
      |=> code[$past(code_idx)] == $past(code_val))
      else $error("state write not seen next cycle");

   a_irq_masked: assert property (@(posedge clk) disable iff (!rst_n)
      tx_done && tx_busy && buffer_irq_mask[win_idx] |=> irq)
      else $error("completed buffer with mask set gave no interrupt");

   a_abort_flags: assert property (@(posedge clk) disable iff (!rst_n)
      code_wr && code_val == CMTS_CODE_ABORT && abort_enable_bit
      && code[code_idx] == CMTS_CODE_TXDATA && !tx_busy
      |=> buffer_done_flag[$past(code_idx)] && code[$past(code_idx)] == CMTS_CODE_ABORT)
      else $error("abort did not flag the buffer");

   a_inactive_silent: assert property (@(posedge clk) disable iff (!rst_n)
      code_wr && code_val == CMTS_CODE_TXOFF && !tx_busy && !flag_clr[code_idx]
      && !buffer_done_flag[code_idx] |=> !buffer_done_flag[$past(code_idx)])
      else $error("inactive write raised a flag");

   a_deact_no_arm: assert property (@(posedge clk) disable iff (!rst_n)
      code_wr && code_val == CMTS_CODE_INACT |=> !armed[$past(code_idx)])
      else $error("deactivated buffer still armed");

   a_trigger_scan: assert property (@(posedge clk) disable iff (!rst_n)
      state == CMTS_IDLE && !tx_busy && (intermission_end || rx_sof || code_wr)
      |=> state == CMTS_SCAN && scan_idx == CMTS_IDX_ZERO)
      else $error("trigger did not start a scan");

   a_arm_code: assert property (@(posedge clk) disable iff (!rst_n)
      code_wr && code_val == CMTS_CODE_TXDATA && !tx_done |=> armed[$past(code_idx)])
      else $error("arming write did not arm buffer");
endmodule : cmts_scheduler

// File: test/cmts_bus_model.sv
// Bus engine stand-in: takes the offered frame, then reports it sent.
// Assumes the scheduler offers frames on tx_req in the module clock domain.
`timescale 1ns/1ps
module cmts_bus_model (
   input  wire logic clk,
   input  wire logic hold,
   input  wire logic tx_req,
   output logic      tx_ack,
   output logic      tx_done,
   output logic      intermission_end
);
   logic [3:0] cnt = 4'h0;
   initial {tx_ack, tx_done, intermission_end} = 3'h0;
   // Hold models a busy bus, so an offer can be left standing for abort tests
   always @(posedge clk) begin
      tx_ack           <= tx_req && !hold && !tx_ack && cnt == 4'h0;
      tx_done          <= cnt == 4'h1;
      intermission_end <= tx_done;
      if (tx_ack) cnt <= 4'h8;
      else if (cnt != 4'h0) cnt <= cnt - 4'h1;
   end
endmodule : cmts_bus_model

// File: test/tb.sv
// Self-checking bench for the transmit mailbox scheduler.
// Assumes the bus model above answers for the bus engine.
`timescale 1ns/1ps
module tb;
   import cmts_pkg::*;
   logic        clk = 1'b0, arst_n = 1'b0, abort_enable_bit = 1'b0, code_wr = 1'b0;
   logic        id_wr = 1'b0, data_wr = 1'b0, rx_sof = 1'b0, hold = 1'b0;
   logic [3:0]  code_idx = 4'h0, code_val = 4'h0, dlc_val = 4'h0, rd_idx = 4'h0, rd_code, tx_dlc;
   logic [3:0]  seen_dlc;
   logic [28:0] id_val = 29'h0, tx_id, seen_id;
   logic [63:0] data_val = 64'h0, tx_data, seen_data;
   logic [15:0] flag_clr = 16'h0, mask = 16'h0, flags;
   logic        irq, tx_req, tx_ack, tx_done, imend;
   int          err_total = 0, comparisons = 0, cycles = 0;
   typedef struct {logic [3:0] idx; logic [28:0] id; logic [3:0] dlc; logic m;} cmts_row_type;
   cmts_row_type rows [4] = '{'{4'h1, 29'h0000123, 4'h8, 1'b1}, '{4'hf, 29'h1fffffff, 4'h0, 1'b0},
                              '{4'h7, 29'h0abcdef, 4'hf, 1'b1}, '{4'h2, 29'h0000001, 4'h4, 1'b0}};
   cmts_scheduler dut (.clk(clk), .arst_n(arst_n), .code_wr(code_wr),
      .abort_enable_bit(abort_enable_bit),
      .code_idx(code_idx), .code_val(code_val), .id_wr(id_wr), .id_val(id_val), .data_wr(data_wr),
      .data_val(data_val), .dlc_val(dlc_val), .flag_clr(flag_clr), .buffer_irq_mask(mask),
      .intermission_end(imend), .rx_sof(rx_sof), .tx_ack(tx_ack), .tx_done(tx_done),
      .rd_idx(rd_idx), .rd_code(rd_code), .buffer_done_flag(flags), .irq(irq), .tx_req(tx_req),
      .tx_id(tx_id), .tx_data(tx_data), .tx_dlc(tx_dlc));
   cmts_bus_model peer (.clk(clk), .hold(hold), .tx_req(tx_req), .tx_ack(tx_ack),
      .tx_done(tx_done), .intermission_end(imend));
   initial forever #25 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : wrap_up
   task automatic wr_code(input logic [3:0] idx, input logic [3:0] val);
      @(posedge clk) {code_wr, code_idx, code_val} <= {1'b1, idx, val};
      @(posedge clk) code_wr <= 1'b0;
   endtask : wr_code
   task automatic read_code(input logic [3:0] idx, output logic [3:0] code);
      @(posedge clk) rd_idx <= idx;
      repeat (2) @(posedge clk);
      #1 code = rd_code;
   endtask : read_code
   // Host preparation order: clear flag, stop buffer, id, payload, arm, then poke buffer 0
   task automatic prep(input logic [3:0] idx, input logic [28:0] id, input logic [3:0] dlc);
      @(posedge clk) flag_clr <= 16'h0001 << idx;
      @(posedge clk) flag_clr <= 16'h0000;
      wr_code(idx, CMTS_CODE_TXOFF);
      @(posedge clk) {id_wr, code_idx, id_val} <= {1'b1, idx, id};
      @(posedge clk) {id_wr, data_wr, data_val, dlc_val} <= {2'b01, id, 3'h0, id, 3'h0, dlc};
      @(posedge clk) data_wr <= 1'b0;
      wr_code(idx, CMTS_CODE_TXDATA);
      wr_code(CMTS_IDX_ZERO, CMTS_CODE_TXOFF);
      wr_code(CMTS_IDX_ZERO, CMTS_CODE_TXOFF);
   endtask : prep
   task automatic wait_done(input logic [3:0] idx);
      for (int i = 0; i < 300 && flags[idx] !== 1'b1; i++) begin
         @(posedge clk) #1;
         if (tx_req === 1'b1) {seen_id, seen_data, seen_dlc} = {tx_id, tx_data, tx_dlc};
      end
   endtask : wait_done
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) if (++cycles == 20000) begin
      err_total++;
      wrap_up();
   end
   initial begin
      logic [3:0] c;
      repeat (10) @(posedge clk);
      check("reset flags", {flags, irq, tx_req}, 64'h0);
      $display("reset test done");
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      foreach (rows[r]) begin
         @(posedge clk) mask <= {15'h0, rows[r].m} << rows[r].idx;
         prep(rows[r].idx, rows[r].id, rows[r].dlc);
         wait_done(rows[r].idx);
         check("done flag", flags[rows[r].idx], 1'b1);
         check("irq", irq, rows[r].m);
         check("tx id", seen_id, rows[r].id);
         check("tx data", seen_data, {rows[r].id, 3'h0, rows[r].id, 3'h0});
         check("tx dlc", seen_dlc, rows[r].dlc);
         read_code(rows[r].idx, c);
         check("code after send", c, CMTS_CODE_TXOFF);
         $display("row %0d done", r);
      end
      @(posedge clk) {hold, abort_enable_bit} <= 2'b11;
      prep(4'h3, 29'h15, 4'h2);
      repeat (25) @(posedge clk);
      #1 check("offer", tx_req, 1'b1);
      wr_code(4'h3, CMTS_CODE_ABORT);
      read_code(4'h3, c);
      check("abort code", c, CMTS_CODE_ABORT);
      check("abort flag", flags[3], 1'b1);
      @(posedge clk) abort_enable_bit <= 1'b0;
      prep(4'h3, 29'h15, 4'h2);
      wr_code(4'h3, CMTS_CODE_ABORT);
      read_code(4'h3, c);
      check("abort ignored", c, CMTS_CODE_TXDATA);
      wr_code(4'h3, CMTS_CODE_TXOFF);
      read_code(4'h3, c);
      check("txoff code", {c, flags[3]}, {CMTS_CODE_TXOFF, 1'b0});
      wr_code(4'h3, CMTS_CODE_TXDATA);
      wr_code(4'h3, CMTS_CODE_INACT);
      repeat (25) @(posedge clk);
      read_code(4'h3, c);
      check("inactive", {c, tx_req}, {CMTS_CODE_INACT, 1'b0});
      $display("abort test done");
      // Incoming frame start with nothing armed starts a scan, then arm buffer 5: its writes land mid-scan and force the rescan that sends it
      @(posedge clk) {rx_sof, hold} <= 2'b10;
      @(posedge clk) rx_sof <= 1'b0;
      prep(4'h5, 29'h777, 4'h1);
      wait_done(4'h5);
      check("rescan send", {flags[5], seen_id}, {1'b1, 29'h777});
      $display("rescan test done");
      wrap_up();
   end
endmodule : tb
